// >>> logic/cpu4_exec_core.sv
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cpu4_exec_core
  import cpu4_pkg::*;
#(
  parameter int STACK_DEPTH = 8
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // program memory
  output logic [13:0] romAddr,
  input wire logic [9:0] romData,
  // data memory at the current data pointer
  input wire logic [3:0] ramRdData,
  output logic ramWrEn,
  output logic [3:0] ramWrData,
  output logic dpRestore,
  // table address bits and external interrupt
  input wire logic [2:0] tableAddrHigh,
  input wire logic ext0Pin,
  input wire logic ext0Event,
  input wire logic irqEntry,
  input wire logic [13:0] irqVector,
  // control registers seen by other blocks
  output logic irqMasterEnable,
  output logic ext0RequestFlag,
  output logic [3:0] irqCtrlOne,
  output logic [3:0] pinCtrlOne,
  output logic [3:0] timerCtrlOne
);

  core_state_e state_q, state_d;
  logic [3:0] acc_q, acc_d;
  logic [3:0] regB_q, regB_d;
  logic carryFlag_q, carryFlag_d;
  logic skip_q, skip_d;
  logic loadRun_q, loadRun_d;
  logic [13:0] romAddr_q, romAddr_d;
  logic [2:0] stackLevel_q, stackLevel_d;
  logic [13:0] stackMem [STACK_DEPTH];
  logic pushEn;
  logic [13:0] pushVal;
  logic [9:0] firstWord_q;
  logic ramWrEn_q, ramWrEn_d;
  logic [3:0] ramWrData_q, ramWrData_d;
  logic dpRestore_q, dpRestore_d;
  logic irqMasterEnable_q, irqMasterEnable_d;
  logic romBank_q, romBank_d;
  logic ext0Flag_q, ext0Clr;
  logic [3:0] irqCtrlOne_q, irqCtrlOne_d;
  logic [3:0] pinCtrlOne_q, pinCtrlOne_d;
  logic [3:0] timerCtrlOne_q, timerCtrlOne_d;
  logic shadowSave;
  logic [3:0] accShadow_q, regBShadow_q;
  logic carryShadow_q, skipShadow_q, loadRunShadow_q;
  logic run_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] hrdata_q;

  // instruction decode of the word on the program bus
  wire [9:0] w = romData;
  wire isLoadImm = w[9:4] == PFX_LOAD_IMM;
  wire isAddImm = w[9:4] == PFX_ADD_IMM;
  wire isTableRead = w[9:6] == PFX_TABLE_READ;
  wire isSetBit = w[9:2] == PFX_SET_BIT;
  wire isClearBit = w[9:2] == PFX_CLEAR_BIT;
  wire isSkipBit = w[9:2] == PFX_SKIP_BIT;
  wire isNearJump = w[9:7] == PFX_NEAR_JUMP;
  wire isPage2Call = w[9:7] == PFX_PAGE2_CALL;
  wire isFarJump = w[9:5] == PFX_FAR_JUMP;
  wire isFarCall = w[9:5] == PFX_FAR_CALL;
  wire isJumpInd = w == OP_JUMP_INDIRECT;
  wire isCallInd = w == OP_CALL_INDIRECT;
  wire isCmpImm = w == OP_SKIP_EQ_IMM;
  wire isTwoWord = isFarJump | isFarCall | isJumpInd | isCallInd | isCmpImm;
  wire isSubRet = (w == OP_SUB_RETURN) | (w == OP_SUB_RETURN_SKIP);

  // arithmetic results; the fifth bit is the carry out
  wire [4:0] sumMem = {1'b0, acc_q} + {1'b0, ramRdData};
  wire [4:0] sumMemC = sumMem + {4'h0, carryFlag_q};
  wire [4:0] sumImm = {1'b0, acc_q} + {1'b0, w[3:0]};
  wire [3:0] bitMask = 4'h1 << w[1:0];
  wire [13:0] pcNext = romAddr_q + 14'h1;
  wire [2:0] levelUp = stackLevel_q + 3'h1;
  wire [2:0] levelDown = stackLevel_q - 3'h1;
  wire [13:0] stackTop = stackMem[stackLevel_q];
  wire [6:0] regAddrLow = {tableAddrHigh, acc_q};

  // execution gating: a skip or a chained load consumes the word only
  wire inFetch = run_q && state_q == ST_FETCH;
  wire loadSkip = loadRun_q && isLoadImm;
  wire irqTake = inFetch && irqEntry && irqMasterEnable_q;
  wire exec = inFetch && !irqTake && !skip_q && !loadSkip;

  // skip conditions
  wire pendSkip = !irqCtrlOne_q[EXT0_ENABLE_BIT] && ext0Flag_q;
  wire pinSkip = pinCtrlOne_q[EXT0_POLARITY_BIT] ? ext0Pin : !ext0Pin;

  // next-state logic for the whole core
  always_comb
  begin
    state_d = state_q;
    acc_d = acc_q;
    regB_d = regB_q;
    carryFlag_d = carryFlag_q;
    skip_d = skip_q;
    loadRun_d = loadRun_q;
    romAddr_d = romAddr_q;
    stackLevel_d = stackLevel_q;
    pushEn = 1'b0;
    pushVal = pcNext;
    ramWrEn_d = 1'b0;
    ramWrData_d = ramRdData;
    dpRestore_d = 1'b0;
    irqMasterEnable_d = irqMasterEnable_q;
    romBank_d = romBank_q;
    irqCtrlOne_d = irqCtrlOne_q;
    pinCtrlOne_d = pinCtrlOne_q;
    timerCtrlOne_d = timerCtrlOne_q;
    ext0Clr = 1'b0;
    shadowSave = 1'b0;
    if (run_q)
    begin
      unique case (state_q)
        ST_FETCH:
        begin
          romAddr_d = pcNext;
          loadRun_d = 1'b0;
          skip_d = 1'b0;
          if (irqTake)
          begin
            // the word on the bus is not executed; it is returned to later
            shadowSave = 1'b1;
            pushEn = 1'b1;
            pushVal = romAddr_q;
            stackLevel_d = levelUp;
            romAddr_d = irqVector;
            irqMasterEnable_d = 1'b0;
            skip_d = skip_q;
            loadRun_d = loadRun_q;
          end
          else if (skip_q || loadSkip)
          begin
            loadRun_d = loadSkip;
            if (isTwoWord)
            begin
              state_d = ST_SKIP2;
            end
          end
          else if (isLoadImm)
          begin
            acc_d = w[3:0];
            loadRun_d = 1'b1;
          end
          else if (isTableRead)
          begin
            pushEn = 1'b1;
            stackLevel_d = levelUp;
            romAddr_d = {romBank_q, w[5:0], regAddrLow};
            state_d = ST_TBL_DATA;
          end
          else if (w == OP_ADD_MEM)
          begin
            acc_d = sumMem[3:0];
          end
          else if (w == OP_ADD_MEM_CARRY)
          begin
            acc_d = sumMemC[3:0];
            carryFlag_d = sumMemC[4];
          end
          else if (isAddImm)
          begin
            acc_d = sumImm[3:0];
            skip_d = !sumImm[4];
          end
          else if (w == OP_AND_MEM)
          begin
            acc_d = acc_q & ramRdData;
          end
          else if (w == OP_OR_MEM)
          begin
            acc_d = acc_q | ramRdData;
          end
          else if (w == OP_SET_CARRY)
          begin
            carryFlag_d = 1'b1;
          end
          else if (w == OP_CLEAR_CARRY)
          begin
            carryFlag_d = 1'b0;
          end
          else if (w == OP_SKIP_CARRY_ZERO)
          begin
            skip_d = !carryFlag_q;
          end
          else if (w == OP_ACC_INVERT)
          begin
            acc_d = ~acc_q;
          end
          else if (w == OP_ACC_ROTATE)
          begin
            acc_d = {carryFlag_q, acc_q[3:1]};
            carryFlag_d = acc_q[0];
          end
          else if (isSetBit || isClearBit)
          begin
            ramWrEn_d = 1'b1;
            ramWrData_d = isSetBit ? (ramRdData | bitMask) : (ramRdData & ~bitMask);
          end
          else if (isSkipBit)
          begin
            skip_d = !(|(ramRdData & bitMask));
          end
          else if (w == OP_SKIP_EQ_MEM)
          begin
            skip_d = acc_q == ramRdData;
          end
          else if (isNearJump)
          begin
            romAddr_d = {romAddr_q[13:7], w[6:0]};
          end
          else if (isPage2Call)
          begin
            pushEn = 1'b1;
            stackLevel_d = levelUp;
            romAddr_d = {CALL_PAGE_TWO, w[6:0]};
          end
          else if (isTwoWord)
          begin
            state_d = ST_SECOND;
          end
          else if (w == OP_IRQ_RETURN)
          begin
            // one-cycle pop with context restore
            romAddr_d = stackTop;
            stackLevel_d = levelDown;
            acc_d = accShadow_q;
            regB_d = regBShadow_q;
            carryFlag_d = carryShadow_q;
            skip_d = skipShadow_q;
            loadRun_d = loadRunShadow_q;
            dpRestore_d = 1'b1;
          end
          else if (isSubRet)
          begin
            romAddr_d = romAddr_q;
            state_d = ST_RET_WAIT;
          end
          else if (w == OP_IRQ_OFF || w == OP_IRQ_ON)
          begin
            irqMasterEnable_d = w == OP_IRQ_ON;
          end
          else if (w == OP_SKIP_EXT0_PEND)
          begin
            skip_d = pendSkip;
            ext0Clr = pendSkip;
          end
          else if (w == OP_SKIP_EXT0_PIN)
          begin
            skip_d = pinSkip;
          end
          else if (w == OP_ACC_FROM_IRQ1)
          begin
            acc_d = irqCtrlOne_q;
          end
          else if (w == OP_IRQ1_FROM_ACC)
          begin
            irqCtrlOne_d = acc_q;
          end
          else if (w == OP_ACC_FROM_PINCTL)
          begin
            acc_d = pinCtrlOne_q;
          end
          else if (w == OP_PINCTL_FROM_ACC)
          begin
            pinCtrlOne_d = acc_q;
          end
          else if (w == OP_ACC_FROM_TIMER1)
          begin
            acc_d = timerCtrlOne_q;
          end
          else if (w == OP_TIMER1_FROM_ACC)
          begin
            timerCtrlOne_d = acc_q;
          end
          else if (w == OP_UPPER_BANK || w == OP_LOWER_BANK)
          begin
            romBank_d = w == OP_UPPER_BANK;
          end
        end
        ST_SECOND:
        begin
          // for far jumps and calls the second word carries the high page bits and the offset
          state_d = ST_FETCH;
          romAddr_d = pcNext;
          if (firstWord_q == OP_SKIP_EQ_IMM)
          begin
            skip_d = acc_q == w[3:0];
          end
          else if (firstWord_q == OP_JUMP_INDIRECT || firstWord_q == OP_CALL_INDIRECT)
          begin
            romAddr_d = {w[8:6], w[3:0], regAddrLow};
          end
          else
          begin
            romAddr_d = {w[8:7], firstWord_q[4:0], w[6:0]};
          end
          if (firstWord_q == OP_CALL_INDIRECT || firstWord_q[9:5] == PFX_FAR_CALL)
          begin
            pushEn = 1'b1;
            stackLevel_d = levelUp;
          end
        end
        ST_SKIP2:
        begin
          romAddr_d = pcNext;
          state_d = ST_FETCH;
        end
        ST_TBL_DATA:
        begin
          regB_d = w[7:4];
          acc_d = w[3:0];
          state_d = ST_TBL_BACK;
        end
        ST_TBL_BACK:
        begin
          romAddr_d = stackTop;
          stackLevel_d = levelDown;
          state_d = ST_FETCH;
        end
        ST_RET_WAIT:
        begin
          romAddr_d = stackTop;
          stackLevel_d = levelDown;
          skip_d = firstWord_q == OP_SUB_RETURN_SKIP;
          state_d = ST_FETCH;
        end
      endcase
    end
  end

  // architectural state
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= ST_FETCH;
      acc_q <= 4'h0;
      regB_q <= 4'h0;
      carryFlag_q <= 1'b0;
      skip_q <= 1'b0;
      loadRun_q <= 1'b0;
      romAddr_q <= 14'h0;
      stackLevel_q <= STACK_LEVEL_RESET;
    end
    else
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      regB_q <= regB_d;
      carryFlag_q <= carryFlag_d;
      skip_q <= skip_d;
      loadRun_q <= loadRun_d;
      romAddr_q <= romAddr_d;
      stackLevel_q <= stackLevel_d;
    end
  end

  // control registers; reset also returns tables to the lower bank
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irqMasterEnable_q <= 1'b0;
      romBank_q <= 1'b0;
      irqCtrlOne_q <= 4'h0;
      pinCtrlOne_q <= 4'h0;
      timerCtrlOne_q <= 4'h0;
      ext0Flag_q <= 1'b0;
      ramWrEn_q <= 1'b0;
      ramWrData_q <= 4'h0;
      dpRestore_q <= 1'b0;
    end
    else
    begin
      irqMasterEnable_q <= irqMasterEnable_d;
      romBank_q <= romBank_d;
      irqCtrlOne_q <= irqCtrlOne_d;
      pinCtrlOne_q <= pinCtrlOne_d;
      timerCtrlOne_q <= timerCtrlOne_d;
      ext0Flag_q <= ext0Event | (ext0Flag_q & ~ext0Clr); // new request beats the clear
      ramWrEn_q <= ramWrEn_d;
      ramWrData_q <= ramWrData_d;
      dpRestore_q <= dpRestore_d;
    end
  end

  // return stack and the latched first word; no reset needed on data
  always_ff @(posedge clock)
  begin
    if (pushEn)
    begin
      stackMem[levelUp] <= pushVal;
    end
    if (inFetch)
    begin
      firstWord_q <= w;
    end
  end

  // context saved on interrupt entry for the interrupt return
  always_ff @(posedge clock)
  begin
    if (shadowSave)
    begin
      accShadow_q <= acc_q;
      regBShadow_q <= regB_q;
      carryShadow_q <= carryFlag_q;
      skipShadow_q <= skip_q;
      loadRunShadow_q <= loadRun_q;
    end
  end

  // bus slave: zero wait, read data registered in the address phase
  wire busTake = hsel && hready && htrans == HTRANS_NONSEQ;
  wire [31:0] stateWord = {6'h00, romAddr_q, stackLevel_q, carryFlag_q, regB_q, acc_q};
  wire [31:0] ctrlWord = {25'h0, romBank_q, ext0Flag_q, irqMasterEnable_q, 3'h0, run_q};
  wire [31:0] readMux = (haddr == REG_STATE_OFS) ? stateWord :
                        (haddr == REG_CTRL_OFS) ? ctrlWord : 32'h0;

  // software stalls the core by clearing the run bit
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h0;
      hrdata_q <= 32'h0;
      run_q <= 1'b1;
    end
    else
    begin
      wrPend_q <= busTake && hwrite;
      wrAddr_q <= haddr;
      hrdata_q <= (busTake && !hwrite) ? readMux : 32'h0;
      if (wrPend_q && wrAddr_q == REG_CTRL_OFS)
      begin
        run_q <= hwdata[CTRL_RUN_BIT];
      end
    end
  end

  // every output but hreadyout and hresp, which are tied constant, comes straight from flip-flops
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign romAddr = romAddr_q;
  assign ramWrEn = ramWrEn_q;
  assign ramWrData = ramWrData_q;
  assign dpRestore = dpRestore_q;
  assign irqMasterEnable = irqMasterEnable_q;
  assign ext0RequestFlag = ext0Flag_q;
  assign irqCtrlOne = irqCtrlOne_q;
  assign pinCtrlOne = pinCtrlOne_q;
  assign timerCtrlOne = timerCtrlOne_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_far_jump;
    exec && isFarJump ##1 run_q;
  endsequence
  sequence s_sub_ret;
    exec && isSubRet ##1 run_q;
  endsequence

  a_add_keeps_carry: assert property (exec && w == OP_ADD_MEM |=> $stable(carryFlag_q))
    else $error("add memory changed carry");
  a_carry_add_sum: assert property (exec && w == OP_ADD_MEM_CARRY
      |=> {carryFlag_q, acc_q} == $past(sumMemC))
    else $error("add with carry result wrong");
  a_imm_add_skip: assert property (exec && isAddImm |=> skip_q == !$past(sumImm[4]))
    else $error("add immediate skip wrong");
  a_invert_acc: assert property (exec && w == OP_ACC_INVERT |=> acc_q == ~$past(acc_q))
    else $error("acc invert wrong");
  a_far_jump_cycles: assert property (s_far_jump
      |-> state_q == ST_SECOND ##1 state_q == ST_FETCH)
    else $error("far jump did not take two cycles");
  a_sub_ret_pop: assert property (s_sub_ret
      |=> romAddr_q == $past(stackTop) && stackLevel_q == $past(stackLevel_q) - 3'h1)
    else $error("sub return pop wrong");
  a_skip_no_effect: assert property (inFetch && skip_q && !irqTake
      |=> $stable(acc_q) && $stable(carryFlag_q) && !ramWrEn_q)
    else $error("skipped word had an effect");
  a_load_chain: assert property (exec && isLoadImm ##1 (inFetch && isLoadImm && !irqTake)
      |=> acc_q == $past(acc_q))
    else $error("chained load executed");
  a_ext0_clear: assert property (exec && w == OP_SKIP_EXT0_PEND && pendSkip && !ext0Event
      |=> skip_q && !ext0Flag_q)
    else $error("ext0 pending test wrong");
  a_bank_reset: assert property (@(posedge clock) disable iff (1'b0) rst |=> !romBank_q)
    else $error("bank not lower after reset");

endmodule
`default_nettype wire

// >>> logic/cpu4_pkg.sv
`default_nettype none
package cpu4_pkg;
  // full-word opcodes; OP_SKIP_EQ_IMM, OP_JUMP_INDIRECT and OP_CALL_INDIRECT take a second word
  localparam logic [9:0] OP_ADD_MEM = 10'h00a;
  localparam logic [9:0] OP_ADD_MEM_CARRY = 10'h00b;
  localparam logic [9:0] OP_AND_MEM = 10'h018;
  localparam logic [9:0] OP_OR_MEM = 10'h019;
  localparam logic [9:0] OP_SET_CARRY = 10'h007;
  localparam logic [9:0] OP_CLEAR_CARRY = 10'h006;
  localparam logic [9:0] OP_SKIP_CARRY_ZERO = 10'h02f;
  localparam logic [9:0] OP_ACC_INVERT = 10'h01c;
  localparam logic [9:0] OP_ACC_ROTATE = 10'h01d;
  localparam logic [9:0] OP_SKIP_EQ_MEM = 10'h026;
  localparam logic [9:0] OP_SKIP_EQ_IMM = 10'h025;
  localparam logic [9:0] OP_JUMP_INDIRECT = 10'h010;
  localparam logic [9:0] OP_CALL_INDIRECT = 10'h030;
  localparam logic [9:0] OP_IRQ_RETURN = 10'h046;
  localparam logic [9:0] OP_SUB_RETURN = 10'h044;
  localparam logic [9:0] OP_SUB_RETURN_SKIP = 10'h045;
  localparam logic [9:0] OP_IRQ_OFF = 10'h004;
  localparam logic [9:0] OP_IRQ_ON = 10'h005;
  localparam logic [9:0] OP_SKIP_EXT0_PEND = 10'h038;
  localparam logic [9:0] OP_SKIP_EXT0_PIN = 10'h03a;
  localparam logic [9:0] OP_ACC_FROM_IRQ1 = 10'h054;
  localparam logic [9:0] OP_IRQ1_FROM_ACC = 10'h03f;
  localparam logic [9:0] OP_ACC_FROM_PINCTL = 10'h253;
  localparam logic [9:0] OP_PINCTL_FROM_ACC = 10'h217;
  localparam logic [9:0] OP_ACC_FROM_TIMER1 = 10'h24b;
  localparam logic [9:0] OP_TIMER1_FROM_ACC = 10'h20e;
  localparam logic [9:0] OP_UPPER_BANK = 10'h2b0;
  localparam logic [9:0] OP_LOWER_BANK = 10'h2b1;
  // opcode prefixes that carry an immediate field
  localparam logic [5:0] PFX_LOAD_IMM = 6'h07;
  localparam logic [5:0] PFX_ADD_IMM = 6'h06;
  localparam logic [3:0] PFX_TABLE_READ = 4'h2;
  localparam logic [7:0] PFX_SET_BIT = 8'h17;
  localparam logic [7:0] PFX_CLEAR_BIT = 8'h13;
  localparam logic [7:0] PFX_SKIP_BIT = 8'h08;
  localparam logic [2:0] PFX_NEAR_JUMP = 3'h3;
  localparam logic [2:0] PFX_PAGE2_CALL = 3'h2;
  localparam logic [4:0] PFX_FAR_JUMP = 5'h07;
  localparam logic [4:0] PFX_FAR_CALL = 5'h06;
  // reset values and fixed targets
  localparam logic [2:0] STACK_LEVEL_RESET = 3'h7;
  localparam logic [6:0] CALL_PAGE_TWO = 7'h02;
  localparam int EXT0_ENABLE_BIT = 0;
  localparam int EXT0_POLARITY_BIT = 2;
  // register map
  localparam logic [7:0] REG_STATE_OFS = 8'h00;
  localparam logic [7:0] REG_CTRL_OFS = 8'h04;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    ST_FETCH, ST_SECOND, ST_SKIP2, ST_TBL_DATA, ST_TBL_BACK, ST_RET_WAIT
  } core_state_e;
endpackage
`default_nettype wire

// >>> testbench/cpu4_alu_branch_int_decoder_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cpu4_alu_branch_int_decoder_tb_top
  import cpu4_pkg::*;
;
  // bench signals
  logic clock, rst, hsel, hwrite, hready, hresp, ext0Pin, ramWrEn, c, ext0Ev, irqEntry;
  logic [7:0] haddr;
  logic [1:0] htrans, j;
  logic [2:0] tableAddrHigh;
  logic [31:0] hwdata, hrdata, rd;
  logic [13:0] romAddr;
  logic [9:0] romData;
  logic [9:0] prog [0:15];
  logic [3:0] ramQ, ramWrData, a, m, n, ramInit, pinCtl;
  int num_errors = 0;
  int compares = 0;
  int k;

  // free running 125 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // memories answer in the same cycle; rom aliases every 16 words, programs stay short
  always_comb romData = prog[romAddr[3:0]];
  // one driver for the nibble: reset loads the scenario's operand
  always @(posedge clock)
  begin
    if (rst)
      ramQ <= ramInit;
    else if (ramWrEn)
      ramQ <= ramWrData;
  end

  cpu4_exec_core dut (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .romAddr(romAddr),
    .romData(romData), .ramRdData(ramQ), .ramWrEn(ramWrEn), .ramWrData(ramWrData),
    .dpRestore(), .tableAddrHigh(tableAddrHigh), .ext0Pin(ext0Pin),
    .ext0Event(ext0Ev), .irqEntry(irqEntry), .irqVector(14'h0008),
    .irqMasterEnable(), .ext0RequestFlag(), .irqCtrlOne(), .pinCtrlOne(pinCtl),
    .timerCtrlOne()
  );

  task automatic tally_and_finish();
    $display("mismatches=%0d comparisons=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single transfer; both phases are held until hready is seen high
  // only the watchdog ends a wait, so a stuck slave is counted as a failure
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // expected {carry, acc} once the program has parked
  function automatic logic [4:0] model(input int s, input logic cy, input logic [3:0] x,
      input logic [3:0] y, input logic [3:0] z, input logic [1:0] b, input logic p);
    logic [4:0] sm, si;
    sm = {1'b0, x} + {1'b0, y};
    si = {1'b0, x} + {1'b0, z};
    case (s)
      1: return {cy, sm[3:0]};
      2: return sm + {4'h0, cy};
      3: return {cy, si[4] ? ~si[3:0] : si[3:0]};
      4: return {cy, (x == y) ? x : ~x};
      5: return {cy, x & y};
      6: return {cy, x | y};
      7: return {x[0], cy, x[3:1]};
      8: return {cy, y[b] ? ~x : x};
      9: return {cy, p ? ~x : x};
      11: return {cy, cy ? ~x : x};
      13: return {cy, z};
      14: return {cy, (x == z) ? x : ~x};
      15: return {cy, (x[2] ? p : !p) ? x : ~x};
      16: return {cy, p ? x : ~x};
      18: return {cy, ~x};
      default: return {cy, x};
    endcase
  endfunction

  // carry op, acc load, op under test, optional invert, then a jump to itself
  task automatic run_case(input int s);
    a = 4'($urandom);
    m = 4'($urandom);
    n = 4'($urandom);
    c = 1'($urandom);
    j = 2'($urandom);
    if (s == 14 && j[0])
      n = a; // corner: immediate equal to acc
    for (int i = 0; i < 16; i++)
      prog[i] = {PFX_NEAR_JUMP, 7'(i)};
    prog[0] = c ? OP_SET_CARRY : OP_CLEAR_CARRY;
    prog[1] = {PFX_LOAD_IMM, a};
    k = (s inside {3, 4, 8, 9, 11, 16, 18}) ? 4 : (s inside {14, 15}) ? 5 : 3;
    if (k > 3)
      prog[k - 1] = OP_ACC_INVERT;
    case (s)
      0: prog[2] = {PFX_LOAD_IMM, n};
      1: prog[2] = OP_ADD_MEM;
      2: prog[2] = OP_ADD_MEM_CARRY;
      3: prog[2] = {PFX_ADD_IMM, n};
      4: prog[2] = OP_SKIP_EQ_MEM;
      5: prog[2] = OP_AND_MEM;
      6: prog[2] = OP_OR_MEM;
      7: prog[2] = OP_ACC_ROTATE;
      8: prog[2] = {PFX_SKIP_BIT, j};
      9: prog[2] = OP_SKIP_EXT0_PIN;
      10: prog[2] = {PFX_SET_BIT, j};
      11: prog[2] = OP_SKIP_CARRY_ZERO;
      13: prog[2] = {PFX_TABLE_READ, 6'h00};
      14:
      begin
        prog[2] = OP_SKIP_EQ_IMM;
        prog[3] = {PFX_LOAD_IMM, n};
      end
      15:
      begin
        prog[2] = OP_PINCTL_FROM_ACC;
        prog[3] = OP_SKIP_EXT0_PIN;
      end
      16: prog[2] = OP_SKIP_EXT0_PEND;
      17:
      begin
        // handler at 8 inverts acc and sets a ram bit; the return restores acc
        prog[2] = OP_IRQ_ON;
        prog[8] = OP_ACC_INVERT;
        prog[9] = {PFX_SET_BIT, j};
        prog[10] = OP_IRQ_RETURN;
      end
      18:
      begin
        // page-2 call reaches word 8 through the rom alias; the return skips word 3
        prog[2] = {PFX_PAGE2_CALL, 7'h08};
        prog[8] = OP_ACC_INVERT;
        prog[9] = OP_SUB_RETURN_SKIP;
      end
      default: prog[2] = OP_UPPER_BANK;
    endcase
    if (s == 13)
      n = prog[a][3:0]; // the low nibble of the aliased word lands in acc
    @(posedge clock);
    ramInit <= m;
    ext0Pin <= 1'($urandom);
    tableAddrHigh <= 3'($urandom);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    ext0Ev <= s == 16 && ext0Pin; // request pends before the test word
    irqEntry <= s == 17;
    @(posedge clock);
    ext0Ev <= 1'b0;
    repeat (13) @(posedge clock);
    irqEntry <= 1'b0;
    bus(1'b0, REG_STATE_OFS, 32'h0);
    chk({rd[25:12], rd[8], rd[3:0]}, {14'(k), model(s, c, a, m, n, j, ext0Pin)});
    chk({rd[11:9], rd[7:4]}, {3'h7, ((s == 13) ? prog[a][7:4] : 4'h0)});
    if (s == 15)
      chk(32'(pinCtl), 32'(a));
    bus(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rd & 32'h00000071, {25'h0, s == 12, 6'h01});
    if (s == 10 || s == 17)
      chk(32'(ramQ), 32'(m | (4'h1 << j)));
  endtask

  // main sequence: every case several times with fresh random operands
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    ext0Pin = 1'b0;
    tableAddrHigh = 3'h0;
    ramInit = 4'h0;
    ext0Ev = 1'b0;
    irqEntry = 1'b0;
    void'($urandom(32'h9a8e37ca));
    for (int i = 0; i < 16; i++)
      prog[i] = {PFX_NEAR_JUMP, 7'(i)};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int it = 0; it < 76; it++)
      run_case(it % 19);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, REG_CTRL_OFS, 32'h0);
    bus(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rd & 32'h00000001, 32'h0);
    tally_and_finish();
  end

  // a hung handshake ends the run through the same closing task
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
